// >>> rtl/io_expander_regs.svh
`ifndef IO_EXPANDER_REGS_SVH
`define IO_EXPANDER_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define IOX_ACCESS_OFS      12'h350
`define IOX_ADDR0_OFS       12'h354
`define IOX_ADDR1_OFS       12'h358
`define IOX_IRQ_STATUS_OFS  12'h3e0
`define IOX_IRQ_MASK_OFS    12'h3e4

// ************************************************************
// Field positions
// ************************************************************
`define IOX_PIN_LSB         0
`define IOX_PIN_MSB         15
`define IOX_REFRESH_BIT     24
`define IOX_TEST_BIT        25
`define IOX_SEL_LSB         26
`define IOX_SEL_MSB         29
`define IOX_DONE_BIT        31
`define IOX_EXP0_ADDR_LSB   1
`define IOX_EXP1_ADDR_LSB   9
`define IOX_EXP2_ADDR_LSB   17
`define IOX_EXP4_ADDR_LSB   1
`define IOX_EV_DONE_BIT     0
`define IOX_EV_REFUSED_BIT  1
`define IOX_EV_TIMEOUT_BIT  2

// ************************************************************
// Select codes and reset values
// ************************************************************
`define IOX_SEL_EXP0        4'h0
`define IOX_SEL_EXP1        4'h1
`define IOX_SEL_EXP2        4'h2
`define IOX_SEL_EXP4        4'h4
`define IOX_ACCESS_RST      32'h0000_0000
`define IOX_BUS_ADDR_RST    7'h00
`define IOX_IRQ_RST         3'h0

// ************************************************************
// Timing
// ************************************************************
`define IOX_CLK_MHZ         40
`define IOX_SMB_TIMEOUT_US  35000
`define IOX_SMB_TIMEOUT_CYC (`IOX_SMB_TIMEOUT_US * `IOX_CLK_MHZ)

`endif

// >>> rtl/io_expander_pkg.sv
package io_expander_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int PIN_W   = 16;
    localparam int NUM_EXP = 4;
    localparam int EV_W    = 3;

    // ************************************************************
    // Transaction engine
    // ************************************************************
    typedef enum logic [2:0] {
        ENG_IDLE   = 3'b001,
        ENG_WAIT   = 3'b010,
        ENG_FINISH = 3'b100
    } engine_state_type;

    typedef struct packed {
        engine_state_type   state;
        logic [31:0]        count;
        logic               smb_req;
        logic [6:0]         smb_addr;
        logic [PIN_W-1:0]   smb_wdata;
        logic               done;
        logic               timeout;
        logic [PIN_W-1:0]   rdata;
    } engine_regs_type;

    // ************************************************************
    // Register bank
    // ************************************************************
    typedef struct packed {
        logic                             waitrequest;
        logic [31:0]                      readdata;
        logic                             test_mode;
        logic [3:0]                       select;
        logic                             done_flag;
        logic [NUM_EXP-1:0][PIN_W-1:0]    pins;
        logic [NUM_EXP-1:0][PIN_W-1:0]    sw_out;
        logic [NUM_EXP-1:0][6:0]          bus_addr;
        logic [EV_W-1:0]                  irq_status;
        logic [EV_W-1:0]                  irq_mask;
        logic                             irq;
        logic                             launch;
        logic [6:0]                       launch_addr;
        logic [1:0]                       active_idx;
        logic [PIN_W-1:0]                 active_out;
    } access_regs_type;

endpackage : io_expander_pkg

// >>> rtl/expander_txn_engine.sv
`timescale 1ns/1ps
`include "io_expander_regs.svh"

module expander_txn_engine #(
    parameter int TIMEOUT_CYCLES = `IOX_SMB_TIMEOUT_CYC
) (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          start_i,
    input  wire logic [6:0]                    addr_i,
    input  wire logic [io_expander_pkg::PIN_W-1:0] wdata_i,
    input  wire logic                          smb_done_i,
    input  wire logic [io_expander_pkg::PIN_W-1:0] smb_rdata_i,
    output logic                               busy_o,
    output logic                               done_o,
    output logic                               timeout_o,
    output logic [io_expander_pkg::PIN_W-1:0]  rdata_o,
    output logic                               smb_req_o,
    output logic [6:0]                         smb_addr_o,
    output logic [io_expander_pkg::PIN_W-1:0]  smb_wdata_o
);
    import io_expander_pkg::*;

    engine_regs_type st;
    engine_regs_type next_st;

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Request is held until the bus engine answers, so a lost
    // answer cannot wedge the bank: the watchdog ends the wait.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.timeout = 1'b0;
        case (st.state)
            ENG_IDLE: begin
                if (start_i) begin
                    next_st.state = ENG_WAIT;
                    next_st.smb_req = 1'b1;
                    next_st.smb_addr = addr_i;
                    next_st.smb_wdata = wdata_i;
                    next_st.count = '0;
                end
            end
            ENG_WAIT: begin
                next_st.count = st.count + 32'h1;
                if (smb_done_i) begin
                    next_st.rdata = smb_rdata_i;
                    next_st.done = 1'b1;
                    next_st.smb_req = 1'b0;
                    next_st.state = ENG_FINISH;
                end else if (st.count == 32'(TIMEOUT_CYCLES - 1)) begin
                    next_st.done = 1'b1;
                    next_st.timeout = 1'b1;
                    next_st.smb_req = 1'b0;
                    next_st.state = ENG_FINISH;
                end
            end
            ENG_FINISH: begin
                next_st.state = ENG_IDLE;
            end
            default: begin
                next_st.state = ENG_IDLE;
                next_st.smb_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '0;
            st.state <= ENG_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = (st.state != ENG_IDLE);
    assign done_o = st.done;
    assign timeout_o = st.timeout;
    assign rdata_o = st.rdata;
    assign smb_req_o = st.smb_req;
    assign smb_addr_o = st.smb_addr;
    assign smb_wdata_o = st.smb_wdata;

endmodule : expander_txn_engine

// >>> rtl/io_expander_access_register.sv
// What this block does
// - Each of the 16 pin value bits is one pin of the chosen expander.
// - Reading pin values gives last fetched inputs and last supplied outputs.
// - Pin value writes are dropped while test mode is clear.
// - In test mode expander outputs come from software-written pin bits.
// - Input pin bits stay read-only, even in test mode.
// - Bit 25 sets test mode; core-generated outputs are then ignored.
// - Writing one to bit 24 starts a refresh transaction on the chosen expander.
// - The refresh bit clears itself and always reads zero.
// - Select bits 29:26: codes 0, 1, 2 and 4 pick expanders 0, 1, 2, 4.
// - Bit 31 is a write-one-to-clear flag set when the refresh finishes.
// - Each expander is addressed with its own seven-bit bus address.
`timescale 1ns/1ps
`include "io_expander_regs.svh"

module io_expander_access_register #(
    parameter logic [15:0] INPUT_MASK     = 16'h00ff,
    parameter int          TIMEOUT_CYCLES = `IOX_SMB_TIMEOUT_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic [11:0]               avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic [31:0]                    avs_readdata_o,
    output logic                           avs_waitrequest_o,
    output logic                           irq_o,
    input  wire logic [63:0]               core_outputs_i,
    input  wire logic                      smb_done_i,
    input  wire logic [15:0]               smb_rdata_i,
    output logic                           smb_req_o,
    output logic [6:0]                     smb_addr_o,
    output logic [15:0]                    smb_wdata_o
);
    import io_expander_pkg::*;

    // ****************************************
    // Local constants
    // ****************************************
    // Bits set in INPUT_MASK are expander inputs, the rest outputs
    // Test-mode pin writes change the stored view only; the new
    // outputs reach the expander with the next refresh
    localparam logic [PIN_W-1:0] OUT_MASK = ~INPUT_MASK;
    localparam logic [PIN_W-1:0] PIN_ZERO = 16'h0000;
    localparam int               SLOT_W   = 2;

    // ****************************************
    // Registered state
    // ****************************************
    // Slot 3 holds expander 4, the only code above 2
    access_regs_type st;
    access_regs_type next_st;

    // ****************************************
    // Engine handshake
    // ****************************************
    logic             eng_busy;
    logic             eng_done;
    logic             eng_timeout;
    logic [PIN_W-1:0] eng_rdata;

    // ****************************************
    // Bus decode
    // ****************************************
    logic        req_any;
    logic        accept;
    logic        wr_accept;
    logic        hit_access;
    logic        hit_addr0;
    logic        hit_addr1;
    logic        hit_status;
    logic        hit_mask;
    logic [31:0] cur_access;
    logic [31:0] cur_addr0;
    logic [31:0] cur_addr1;
    logic [31:0] cur_status;
    logic [31:0] cur_mask;

    // ****************************************
    // Helpers
    // ****************************************
    // Only four of the sixteen select codes name an expander
    function automatic logic sel_valid(input logic [3:0] sel);
        case (sel)
            `IOX_SEL_EXP0: sel_valid = 1'b1;
            `IOX_SEL_EXP1: sel_valid = 1'b1;
            `IOX_SEL_EXP2: sel_valid = 1'b1;
            `IOX_SEL_EXP4: sel_valid = 1'b1;
            default:       sel_valid = 1'b0;
        endcase
    endfunction : sel_valid

    // Dense slot for a valid code; reserved codes fold onto 0
    function automatic logic [SLOT_W-1:0] sel_index(input logic [3:0] sel);
        case (sel)
            `IOX_SEL_EXP1: sel_index = 2'h1;
            `IOX_SEL_EXP2: sel_index = 2'h2;
            `IOX_SEL_EXP4: sel_index = 2'h3;
            default:       sel_index = 2'h0;
        endcase
    endfunction : sel_index

    // Byte lanes left out of a write keep the register's value
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Reserved codes have no slot behind them, so they read zero
    function automatic logic [PIN_W-1:0] pin_view(
        input logic [NUM_EXP-1:0][PIN_W-1:0] pins,
        input logic [3:0]                    sel
    );
        if (sel_valid(sel)) begin
            return pins[sel_index(sel)];
        end
        return PIN_ZERO;
    endfunction : pin_view

    // Output values the next transfer drives onto one expander
    function automatic logic [PIN_W-1:0] out_source(
        input logic             test,
        input logic [PIN_W-1:0] sw,
        input logic [PIN_W-1:0] core
    );
        // Test mode hides what the core drives
        if (test) begin
            return sw & OUT_MASK;
        end
        return core & OUT_MASK;
    endfunction : out_source

    // Inputs come from one source, outputs from another
    function automatic logic [PIN_W-1:0] merge_pins(
        input logic [PIN_W-1:0] in_val,
        input logic [PIN_W-1:0] out_val
    );
        return (in_val & INPUT_MASK) | (out_val & OUT_MASK);
    endfunction : merge_pins

    // Slice of the core's output bus that belongs to one slot
    function automatic logic [PIN_W-1:0] core_slot(
        input logic [NUM_EXP*PIN_W-1:0] bus,
        input logic [SLOT_W-1:0]        idx
    );
        return bus[idx*PIN_W +: PIN_W];
    endfunction : core_slot

    // ****************************************
    // Address decode and read images
    // ****************************************
    // Unknown offsets read as zero and ignore writes
    assign req_any    = avs_read_i || avs_write_i;
    assign accept     = req_any && !st.waitrequest;
    assign wr_accept  = accept && avs_write_i;
    assign hit_access = (avs_address_i == `IOX_ACCESS_OFS);
    assign hit_addr0  = (avs_address_i == `IOX_ADDR0_OFS);
    assign hit_addr1  = (avs_address_i == `IOX_ADDR1_OFS);
    assign hit_status = (avs_address_i == `IOX_IRQ_STATUS_OFS);
    assign hit_mask   = (avs_address_i == `IOX_IRQ_MASK_OFS);

    // The refresh bit has no storage, so it always reads zero
    assign cur_access = {st.done_flag, 1'b0, st.select, st.test_mode, 1'b0, 8'h00,
                         pin_view(st.pins, st.select)};
    assign cur_addr0  = {8'h00,
                         st.bus_addr[2], 1'b0,
                         st.bus_addr[1], 1'b0,
                         st.bus_addr[0], 1'b0};
    assign cur_addr1  = {24'h000000, st.bus_addr[3], 1'b0};
    assign cur_status = {{(32-EV_W){1'b0}}, st.irq_status};
    assign cur_mask   = {{(32-EV_W){1'b0}}, st.irq_mask};

    // ****************************************
    // Transaction engine
    // ****************************************
    // One transfer at a time; a refresh that finds it busy is refused.
    // Core outputs are sampled at launch, not tracked in flight.
    // Read data is held from the done pulse until the next answer replaces it.
    expander_txn_engine #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_expander_txn_engine (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .start_i     (st.launch),
        .addr_i      (st.launch_addr),
        .wdata_i     (st.active_out),
        .smb_done_i  (smb_done_i),
        .smb_rdata_i (smb_rdata_i),
        .busy_o      (eng_busy),
        .done_o      (eng_done),
        .timeout_o   (eng_timeout),
        .rdata_o     (eng_rdata),
        .smb_req_o   (smb_req_o),
        .smb_addr_o  (smb_addr_o),
        .smb_wdata_o (smb_wdata_o)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [31:0]       wv;
        logic [3:0]        new_sel;
        logic              new_test;
        logic [SLOT_W-1:0] idx;
        logic [PIN_W-1:0]  pin_new;
        logic              ev_done;
        logic              ev_refused;
        logic              ev_timeout;
        wv             = 32'h0000_0000;
        new_sel        = st.select;
        new_test       = st.test_mode;
        idx            = st.active_idx;
        pin_new        = PIN_ZERO;
        ev_done        = 1'b0;
        ev_refused     = 1'b0;
        ev_timeout     = 1'b0;
        next_st        = st;
        next_st.launch = 1'b0;

        // One wait cycle per request; the answer stands for one edge.
        // Writes take effect at the edge that sees waitrequest low.
        if (req_any && st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            if (hit_access) begin
                next_st.readdata = cur_access;
            end else if (hit_addr0) begin
                next_st.readdata = cur_addr0;
            end else if (hit_addr1) begin
                next_st.readdata = cur_addr1;
            end else if (hit_status) begin
                next_st.readdata = cur_status;
            end else if (hit_mask) begin
                next_st.readdata = cur_mask;
            end else begin
                next_st.readdata = 32'h0000_0000;
            end
        end else if (!st.waitrequest) begin
            next_st.waitrequest = 1'b1;
        end

        // Access register: mode, select, pins and the refresh strobe
        if (wr_accept && hit_access) begin
            wv       = be_merge(cur_access, avs_writedata_i, avs_byteenable_i);
            new_test = wv[`IOX_TEST_BIT];
            new_sel  = wv[`IOX_SEL_MSB:`IOX_SEL_LSB];
            idx      = sel_index(new_sel);
            next_st.test_mode = new_test;
            next_st.select    = new_sel;
            // Pin writes count only in test mode and only on outputs
            if (new_test && sel_valid(new_sel)) begin
                pin_new             = wv[`IOX_PIN_MSB:`IOX_PIN_LSB];
                next_st.sw_out[idx] = pin_new & OUT_MASK;
                next_st.pins[idx]   = merge_pins(st.pins[idx], pin_new);
            end
            if (avs_byteenable_i[3] && avs_writedata_i[`IOX_DONE_BIT]) begin
                next_st.done_flag = 1'b0;
            end
            // The strobe is never stored, which makes it self-clearing
            if (wv[`IOX_REFRESH_BIT]) begin
                if (sel_valid(new_sel) && !eng_busy && !st.launch) begin
                    next_st.launch      = 1'b1;
                    next_st.launch_addr = st.bus_addr[idx];
                    next_st.active_idx  = idx;
                    next_st.active_out  = out_source(new_test, next_st.sw_out[idx],
                                                     core_slot(core_outputs_i, idx));
                end else begin
                    ev_refused = 1'b1;
                end
            end
        end

        // Address registers: seven bits per expander, bit 0 unused
        if (wr_accept && hit_addr0) begin
            wv                  = be_merge(cur_addr0, avs_writedata_i, avs_byteenable_i);
            next_st.bus_addr[0] = wv[`IOX_EXP0_ADDR_LSB +: 7];
            next_st.bus_addr[1] = wv[`IOX_EXP1_ADDR_LSB +: 7];
            next_st.bus_addr[2] = wv[`IOX_EXP2_ADDR_LSB +: 7];
        end
        if (wr_accept && hit_addr1) begin
            wv                  = be_merge(cur_addr1, avs_writedata_i, avs_byteenable_i);
            next_st.bus_addr[3] = wv[`IOX_EXP4_ADDR_LSB +: 7];
        end

        // Event status is write-one-to-clear; the mask is plain storage
        if (wr_accept && hit_status && avs_byteenable_i[0]) begin
            next_st.irq_status = st.irq_status & ~avs_writedata_i[EV_W-1:0];
        end
        if (wr_accept && hit_mask) begin
            wv               = be_merge(cur_mask, avs_writedata_i, avs_byteenable_i);
            next_st.irq_mask = wv[EV_W-1:0];
        end

        // Completion lands after the writes so that a set beats a clear.
        // Timeouts still set the flag so software never waits forever.
        if (eng_done) begin
            ev_done           = 1'b1;
            next_st.done_flag = 1'b1;
            if (eng_timeout) begin
                // A lost answer leaves the stored pins as they were
                ev_timeout = 1'b1;
            end else begin
                next_st.pins[st.active_idx] = merge_pins(eng_rdata, st.active_out);
            end
        end
        next_st.irq_status = next_st.irq_status | {ev_timeout, ev_refused, ev_done};
        next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
    end

    // ****************************************
    // State register
    // ****************************************
    // Only the bus handshake leaves reset at a non-zero level
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st             <= '0;
            st.waitrequest <= 1'b1;
            st.readdata    <= `IOX_ACCESS_RST;
            st.bus_addr    <= {NUM_EXP{`IOX_BUS_ADDR_RST}};
            st.irq_status  <= `IOX_IRQ_RST;
            st.irq_mask    <= `IOX_IRQ_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs, all straight from the state register
    // ****************************************
    assign avs_readdata_o    = st.readdata;
    assign avs_waitrequest_o = st.waitrequest;
    assign irq_o             = st.irq;

endmodule : io_expander_access_register

// >>> sim/expander_model.sv
`timescale 1ns/1ps
module expander_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    output logic             done_o,
    output logic [15:0]      rdata_o
);
    logic [1:0] cnt;
    initial begin
        done_o = 1'b0;
        rdata_o = 16'h0;
        cnt = 2'h0;
    end
    // Data toggles outside a done pulse so stale reads show up
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !done_o) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) begin
                done_o <= 1'b1;
                rdata_o <= 16'h5aa5;
            end
        end
    end
endmodule : expander_model

// >>> sim/io_expander_chk_sva.sv
`timescale 1ns/1ps
module io_expander_chk (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic [11:0] avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        irq_o,
    input wire logic        smb_done_i,
    input wire logic        smb_req_o,
    input wire logic [6:0]  smb_addr_o,
    input wire logic [15:0] smb_wdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire wok = avs_write_i && !avs_waitrequest_o;
    wire go = wok && avs_address_i == 12'h350 && avs_writedata_i[24] && !smb_req_o;
    wire [3:0] sel = avs_writedata_i[29:26];
    chk_refresh_go: assert property (go && sel inside {4'h0, 4'h1, 4'h2, 4'h4} |-> ##[1:8] smb_req_o)
        else $error("refresh did not start");
    chk_reserved_idle: assert property (go && sel inside {4'h3, 4'h5, 4'h6, 4'h7} |=> !smb_req_o [*8])
        else $error("reserved select started a transfer");
    chk_addr_hold: assert property (smb_req_o && !smb_done_i |=> $stable(smb_addr_o))
        else $error("bus address moved");
    chk_wdata_hold: assert property (smb_req_o && !smb_done_i |=> $stable(smb_wdata_o))
        else $error("output data moved");
    chk_req_ends: assert property (smb_req_o && smb_done_i |-> ##[1:4] !smb_req_o)
        else $error("request did not end");
    chk_irq_clear: assert property (wok && avs_address_i == 12'h3e0 && avs_writedata_i == 32'h7 |-> ##[1:3] !irq_o)
        else $error("irq not cleared");
    chk_irq_mask: assert property (wok && avs_address_i == 12'h3e4 && avs_writedata_i == 32'h0 |-> ##[1:3] !irq_o)
        else $error("irq not masked");
    chk_write_ack: assert property (avs_write_i |-> ##[0:16] !avs_waitrequest_o)
        else $error("write not answered");
    cover property (go);
    cover property ($rose(irq_o));
    cover property (smb_req_o && smb_done_i);
endmodule : io_expander_chk
bind io_expander_access_register io_expander_chk u_io_expander_chk (.*);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
    logic        clk_i = 0, reset_i = 1, rd = 0, wr = 0, rq, dn, irq, wt;
    logic [31:0] rb, rdat;
    logic [63:0] core = 64'h0;
    logic [3:0]  sel;
    logic [11:0] adr = 12'h0;
    logic [31:0] wd = 32'h0;
    logic [15:0] sd, sw;
    logic [6:0]  sa;
    int          n_errors = 0, compares = 0, k, hits;
    initial forever #12.5 clk_i = ~clk_i;
    io_expander_access_register #(.INPUT_MASK(16'hfffe), .TIMEOUT_CYCLES(200)) u_io_expander_access_register (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rb), .avs_waitrequest_o(wt),
        .irq_o(irq), .core_outputs_i(core), .smb_done_i(dn), .smb_rdata_i(sd), .smb_req_o(rq),
        .smb_addr_o(sa), .smb_wdata_o(sw));
    expander_model u_expander_model (.clk_i(clk_i), .req_i(rq), .done_o(dn), .rdata_o(sd));
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic wt_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 400 && s !== v; i++) @(posedge clk_i);
        if (i == 400) begin
            n_errors++;
            complete_run();
        end
    endtask : wt_for
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_i);
            if (wt === 1'b0) break;
        end
        rdat = rb;
        wr <= 1'b0;
        rd <= 1'b0;
        if (i == 400) begin
            n_errors++;
            complete_run();
        end
    endtask : bus
    task automatic t_test_mode();
        bus(1, 12'h350, 32'h1);
        bus(0, 12'h350, 32'h0);
        `CHK("pin0 no test", 1'b0, rdat[0])
        bus(1, 12'h350, 32'h0200_0001);
        bus(0, 12'h350, 32'h0);
        `CHK("pin0 test", 1'b1, rdat[0])
        `CHK("test mode", 1'b1, rdat[25])
        core <= 64'hffff_ffff_ffff_ffff;
        bus(1, 12'h350, 32'h0300_0001);
        wt_for(rq, 1'b1);
        `CHK("test out", 16'h0001, sw)
        wt_for(rq, 1'b0);
        bus(0, 12'h350, 32'h0);
        `CHK("test pins", 32'h8200_5aa5, rdat)
        bus(1, 12'h3e0, 32'h7);
    endtask : t_test_mode
    task automatic t_refresh();
        bus(1, 12'h354, 32'h0046_4442);
        bus(1, 12'h358, 32'h48);
        bus(1, 12'h3e4, 32'h1);
        for (k = 0; k < 4; k++) begin
            sel = (k == 3) ? 4'h4 : 4'(k);
            bus(1, 12'h350, {2'b0, sel, 2'b01, 24'h0});
            wt_for(rq, 1'b1);
            `CHK("bus addr", 7'h21 + 7'(k), sa)
            `CHK("core out", 16'h0001, sw)
            wt_for(irq, 1'b1);
            `CHK("irq", 1'b1, irq)
            bus(0, 12'h350, 32'h0);
            `CHK("refresh pins", {2'b10, sel, 2'b00, 24'h00_5aa5}, rdat)
            bus(1, 12'h3e0, 32'h7);
            wt_for(rq, 1'b0);
            @(posedge clk_i);
            `CHK("irq clr", 1'b0, irq)
        end
    endtask : t_refresh
    task automatic t_reserved();
        for (k = 3; k < 8; k++) begin
            if (k == 4) continue;
            hits = 0;
            bus(1, 12'h350, {2'b0, 4'(k), 2'b01, 24'h0});
            repeat (20) @(posedge clk_i) hits += (rq === 1'b1);
            `CHK("reserved req", 0, hits)
            bus(0, 12'h350, 32'h0);
            `CHK("reserved pins", 16'h0, rdat[15:0])
            bus(0, 12'h3e0, 32'h0);
            `CHK("refused event", 1'b1, rdat[1])
        end
    endtask : t_reserved
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        bus(0, 12'h350, 32'h0);
        `CHK("reset access", 32'h0, rdat)
        t_test_mode();
        t_refresh();
        t_reserved();
        complete_run();
    end
endmodule : tb_top
